// file: dv/sid_asserts.sv
// Port checks of the split descriptor block
`default_nettype none
module sid_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        uframe_start,
    input wire logic [2:0]  uframe_num,
    input wire logic        ss_req,
    input wire logic        cs_req,
    input wire logic [2:0]  req_uframe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_tick_ss;
        uframe_start ##1 ss_req;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ss_cause: assert property (ss_req |-> $past(uframe_start))
        else $error("start split without tick");
    a_cs_cause: assert property (cs_req |-> $past(uframe_start))
        else $error("complete split without tick");
    a_slot_echo: assert property (s_tick_ss |->
        req_uframe == $past(uframe_num))
        else $error("request slot differs from tick slot");
    a_req_pulse: assert property ((ss_req || cs_req) && !uframe_start
        |=> !(ss_req || cs_req))
        else $error("split request longer than one cycle");
    a_zero_wait: assert property (s_access |-> pready)
        else $error("access not answered at once");
    a_err_no_data: assert property (s_access ##0 pslverr
        |-> prdata == 32'h0000_0000)
        else $error("error read carries data");
    a_unmapped_err: assert property (psel && !penable && paddr > 8'h14
        |=> pslverr)
        else $error("unmapped access not flagged");
    a_mapped_ok: assert property (psel && !penable && paddr <= 8'h14
        && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access flagged");
endmodule // sid_asserts
bind sid_split_desc sid_asserts u_chk (.pclk, .presetn, .paddr, .psel,
    .penable, .pready, .prdata, .pslverr, .uframe_start, .uframe_num,
    .ss_req, .cs_req, .req_uframe);
`default_nettype wire

// file: dv/sid_partner.sv
// Hub translator stand-in answering split requests
`default_nettype none
module sid_partner (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ss_req,
    input  wire logic       cs_req,
    input  wire logic [2:0] req_uframe,
    input  wire logic [7:0] data_base,
    input  wire logic       flood,
    input  wire logic       rx_ready,
    output var  logic       rx_valid,
    output var  logic [2:0] rx_uframe,
    output var  logic [7:0] rx_byte_in,
    output var  logic       res_valid,
    output var  logic       res_complete,
    output var  logic [2:0] res_uframe,
    output var  logic [2:0] res_code
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_valid <= 1'b0;
            res_valid <= 1'b0;
        end else begin
            // Idle fields toggle so stale values never look valid
            res_valid <= ss_req | cs_req;
            res_complete <= cs_req;
            res_uframe <= (ss_req | cs_req) ? req_uframe : ~res_uframe;
            res_code <= (ss_req | cs_req) ? 3'h7 : ~res_code;
            if (ss_req | flood) begin
                rx_valid <= 1'b1;
                rx_uframe <= req_uframe;
                rx_byte_in <= data_base + {5'h00, req_uframe};
            end else if (rx_valid && rx_ready) begin
                rx_valid <= 1'b0;
                rx_byte_in <= ~rx_byte_in;
            end
        end
    end
endmodule // sid_partner
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench of the split descriptor block
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic dir; logic [7:0] sm, cm; logic [2:0] k;
                           logic es, ec;} sid_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, uframe_start = 1'b0, flood = 1'b0;
    logic [7:0]  paddr = 8'h00, data_base = 8'h40, rx_byte_in;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [4:0]  usb_frame_num = 5'h05;
    logic [2:0]  uframe_num = 3'h0, req_uframe, rx_uframe, res_uframe;
    logic [2:0]  res_code;
    logic        pready, pslverr, ss_req, cs_req, rx_valid, rx_ready, s, c;
    logic        res_valid, res_complete;
    int          errors = 0, check_count = 0, n;
    // IN rows arm start slots zero to three only
    sid_row_t    rows [5] = '{'{1'b1, 8'h01, 8'h04, 3'h0, 1'b1, 1'b0},
        '{1'b1, 8'h00, 8'h00, 3'h2, 1'b0, 1'b1},
        '{1'b1, 8'h04, 8'h00, 3'h5, 1'b0, 1'b0},
        '{1'b1, 8'h08, 8'h00, 3'h3, 1'b1, 1'b0},
        '{1'b0, 8'h02, 8'h02, 3'h1, 1'b1, 1'b0}};
    sid_split_desc uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pready, .prdata, .pslverr, .usb_frame_num, .uframe_start,
        .uframe_num, .ss_req, .cs_req, .req_uframe, .rx_valid, .rx_ready,
        .rx_uframe, .rx_byte_in, .res_valid, .res_complete, .res_uframe,
        .res_code);
    sid_partner u_tt (.pclk, .presetn, .ss_req, .cs_req, .req_uframe,
        .data_base, .flood, .rx_ready, .rx_valid, .rx_uframe, .rx_byte_in,
        .res_valid, .res_complete, .res_uframe, .res_code);
    always #2.5 pclk = ~pclk;
    function automatic logic [31:0] ctrl(input logic hold, dir);
        return {23'h00_0000, hold, 1'b0, 5'h05, dir, 1'b1};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic tick(input logic [2:0] k);
        @(posedge pclk) {uframe_start, uframe_num} <= {1'b1, k};
        @(posedge pclk) uframe_start <= 1'b0;
        #1 {s, c} = {ss_req, cs_req};
        repeat (8) @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Whole run is well under a thousand cycles
    initial begin
        #(4000 * 5);
        errors++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, '0, rd);
        `CHK(rd, 32'h0000_0000)
        $display("reset test done");
        foreach (rows[i]) begin
            apb(1, 8'h10, ctrl(1'b0, rows[i].dir), rd);
            apb(1, 8'h00, {24'h00_0000, rows[i].sm}, rd);
            apb(1, 8'h04, {24'h00_0000, rows[i].cm}, rd);
            tick(rows[i].k);
            `CHK(s, rows[i].es)
            `CHK(c, rows[i].ec)
            $display("row %0d done", i);
        end
        apb(0, 8'h00, '0, rd);
        `CHK(rd, 32'h0006_eb04)
        apb(0, 8'h04, '0, rd);
        `CHK(rd, 32'h0041_4002)
        apb(0, 8'h08, '0, rd);
        `CHK(rd, 32'h0000_0043)
        $display("table test done");
        data_base <= 8'h80;
        usb_frame_num <= 5'h06;
        apb(1, 8'h10, ctrl(1'b0, 1'b1), rd);
        apb(1, 8'h00, 32'h0000_0001, rd);
        tick(3'h0);
        `CHK(s, 1'b0)
        usb_frame_num <= 5'h05;
        tick(3'h0);
        `CHK(s, 1'b1)
        apb(0, 8'h04, '0, rd);
        `CHK(rd[15:8], 8'h80)
        apb(0, 8'h40, '0, rd);
        `CHK({pslverr, rd}, {1'b1, 32'h0000_0000})
        $display("overwrite test done");
        // Hold the drain so the buffer must fill and refuse
        apb(1, 8'h10, ctrl(1'b1, 1'b1), rd);
        flood <= 1'b1;
        for (n = 0; n < 100 && rx_ready; n++) @(posedge pclk);
        apb(0, 8'h14, '0, rd);
        `CHK({rx_ready, rd[16:12]}, 6'h10)
        flood <= 1'b0;
        apb(1, 8'h10, ctrl(1'b0, 1'b1), rd);
        repeat (40) @(posedge pclk);
        apb(0, 8'h14, '0, rd);
        `CHK({rx_ready, rd[16:12]}, 6'h20)
        $display("buffer test done");
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire

// file: src/sid_defines.vh
// Register offsets, field positions and reset values of the split descriptor
`ifndef SID_DEFINES_VH
`define SID_DEFINES_VH

`define SID_ADDR_SLOT_STATUS  8'h00
`define SID_ADDR_CSPLIT_BYTES 8'h04
`define SID_ADDR_BYTES_MID    8'h08
`define SID_ADDR_BYTES_TOP    8'h0c
`define SID_ADDR_CTRL         8'h10
`define SID_ADDR_STATE        8'h14

`define SID_CTRL_ENABLE_BIT   0
`define SID_CTRL_DIR_IN_BIT   1
`define SID_CTRL_FRAME_LSB    2
`define SID_CTRL_FRAME_MSB    6
`define SID_CTRL_HOLD_BIT     8

`define SID_CTRL_RESET        32'h0000_0000
`define SID_MASK_RESET        8'h00
`define SID_STATUS_RESET      24'h00_0000
`define SID_BYTE_RESET        8'h00

`define SID_CODE_XACT_ERR_BIT 0
`define SID_CODE_BABBLE_BIT   1
`define SID_CODE_UNDERRUN_BIT 2
`define SID_CODE_IN_KEEP      3'h3
`define SID_CODE_OUT_KEEP     3'h5
`define SID_IN_SS_LEGAL       8'h0f

`define SID_FIFO_DEPTH        16
`define SID_FIFO_PTR_W        4
`define SID_FIFO_WIDTH        12

`endif

// file: src/sid_fifo.v
// Synchronous FIFO with valid/ready on both sides
`default_nettype none

module sid_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 16,
    parameter PTR_W = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [PTR_W:0]   level
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr;
    reg [PTR_W-1:0] rd_ptr;
    reg [PTR_W:0]   count;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count != DEPTH[PTR_W:0]);
    assign out_valid = (count != {(PTR_W+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign level     = count;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            count  <= {(PTR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count <= count + {{PTR_W{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count <= count - {{PTR_W{1'b0}}, 1'b1};
            end
        end
    end

endmodule // sid_fifo

`default_nettype wire

// file: src/sid_split_desc.v
// Upper words of the split interrupt transfer descriptor with APB access
// Operation
// R01: Store received byte when start slot armed, frame matches
// R02: Newest received byte overwrites its slot field
// R03: Software sets mask bits, hardware clears after processing
// R04: Complete splits scheduled only for IN transfers
// R05: Mask bit k places split in microframe k
// R06: Three-bit result code stored per microframe slot
// R07: Code bits: error, babble IN, underrun OUT
// R08: IN start splits only in microframes zero to three
`default_nettype none
`include "sid_defines.vh"

module sid_split_desc (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    input  wire [4:0]  usb_frame_num,
    input  wire        uframe_start,
    input  wire [2:0]  uframe_num,
    output reg         ss_req,
    output reg         cs_req,
    output reg  [2:0]  req_uframe,
    input  wire        rx_valid,
    output wire        rx_ready,
    input  wire [2:0]  rx_uframe,
    input  wire [7:0]  rx_byte_in,
    input  wire        res_valid,
    input  wire        res_complete,
    input  wire [2:0]  res_uframe,
    input  wire [2:0]  res_code
);

    reg  [31:0] ctrl;
    reg  [7:0]  start_split_slot_mask;
    reg  [7:0]  complete_split_slot_mask;
    reg  [7:0]  ss_armed;
    reg  [23:0] result_code;
    reg  [7:0]  rx_byte_mem [0:7];
    reg  [2:0]  last_uframe;
    reg  [31:0] next_prdata;
    reg         next_pslverr;

    wire        setup_phase = psel & ~penable;
    wire        access_wr   = psel & penable & pwrite;
    wire        wr_status   = access_wr & (paddr == `SID_ADDR_SLOT_STATUS);
    wire        wr_csplit   = access_wr & (paddr == `SID_ADDR_CSPLIT_BYTES);
    wire        wr_ctrl     = access_wr & (paddr == `SID_ADDR_CTRL);

    wire        enable      = ctrl[`SID_CTRL_ENABLE_BIT];
    wire        dir_in      = ctrl[`SID_CTRL_DIR_IN_BIT];
    wire [4:0]  frame_sel   = ctrl[`SID_CTRL_FRAME_MSB:`SID_CTRL_FRAME_LSB];
    wire        drain_hold  = ctrl[`SID_CTRL_HOLD_BIT];
    wire        frame_hit   = enable & (usb_frame_num == frame_sel);

    // IN transfers never arm start splits beyond microframe three
    wire [7:0]  ss_legal    = dir_in ? `SID_IN_SS_LEGAL : 8'hff; // R08
    wire [7:0]  ss_eff      = start_split_slot_mask & ss_legal;
    wire [2:0]  code_keep   = dir_in ? `SID_CODE_IN_KEEP
                                     : `SID_CODE_OUT_KEEP; // R07

    wire [`SID_FIFO_WIDTH-1:0] fifo_in;
    wire [`SID_FIFO_WIDTH-1:0] fifo_out;
    wire                       fifo_out_valid;
    wire                       fifo_out_ready;
    wire [`SID_FIFO_PTR_W:0]   fifo_level;
    wire                       rx_accept;
    wire                       drain_fire;

    // Qualify at arrival: masks may be cleared before the entry drains
    assign rx_accept = frame_hit & (ss_eff[rx_uframe] | ss_armed[rx_uframe]); // R01
    assign fifo_in   = {rx_accept, rx_uframe, rx_byte_in};

    // Draining stalls while software holds it or rewrites slot masks
    assign fifo_out_ready = ~drain_hold & ~wr_status & ~wr_csplit;
    assign drain_fire     = fifo_out_valid & fifo_out_ready;

    sid_fifo #(
        .WIDTH (`SID_FIFO_WIDTH),
        .DEPTH (`SID_FIFO_DEPTH),
        .PTR_W (`SID_FIFO_PTR_W)
    ) u_rx_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );

    wire        drain_ok    = fifo_out[11];
    wire [2:0]  drain_slot  = fifo_out[10:8];
    wire [7:0]  drain_byte  = fifo_out[7:0];

    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_slot
            localparam [2:0] SLOT = k;
            wire slot_res = res_valid & (res_uframe == SLOT);
            wire ss_clr   = slot_res & ~res_complete;
            wire cs_clr   = slot_res & res_complete;
            wire ss_set   = wr_status & pwdata[k];
            wire cs_set   = wr_csplit & pwdata[k];
            wire ss_issue = uframe_start & frame_hit & ss_eff[k]
                            & (uframe_num == SLOT);

            // A software set in the same cycle as a hardware clear wins
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    start_split_slot_mask[k]    <= 1'b0;
                    complete_split_slot_mask[k] <= 1'b0;
                end else begin
                    start_split_slot_mask[k] <=
                        (start_split_slot_mask[k] & ~ss_clr) | ss_set; // R03
                    complete_split_slot_mask[k] <=
                        (complete_split_slot_mask[k] & ~cs_clr) | cs_set; // R03
                end
            end

            // Remembers an issued start split until software rearms the slot
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ss_armed[k] <= 1'b0;
                end else if (ss_issue) begin
                    ss_armed[k] <= 1'b1;
                end else if (ss_set) begin
                    ss_armed[k] <= 1'b0;
                end
            end

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    result_code[3*k+2:3*k] <= 3'h0;
                end else if (slot_res) begin
                    result_code[3*k+2:3*k] <= res_code & code_keep; // R06
                end
            end

            // No guard on older contents: every accepted arrival for the slot replaces its byte
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_byte_mem[k] <= `SID_BYTE_RESET;
                end else if (drain_fire && drain_ok
                             && drain_slot == SLOT) begin
                    rx_byte_mem[k] <= drain_byte; // R02
                end
            end
        end
    endgenerate

    // Split scheduling at each microframe start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ss_req      <= 1'b0;
            cs_req      <= 1'b0;
            req_uframe  <= 3'h0;
            last_uframe <= 3'h0;
        end else begin
            ss_req <= uframe_start & frame_hit & ss_eff[uframe_num]; // R05
            cs_req <= uframe_start & frame_hit & dir_in
                      & complete_split_slot_mask[uframe_num]; // R04
            if (uframe_start) begin
                req_uframe  <= uframe_num; // R05
                last_uframe <= uframe_num;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `SID_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= {23'h00_0000, pwdata[8], 1'b0, pwdata[6:0]};
        end
    end

    // Read data is captured in the setup cycle; the access cycle shows it
    always @* begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            `SID_ADDR_SLOT_STATUS: begin
                next_prdata = {result_code, start_split_slot_mask};
            end
            `SID_ADDR_CSPLIT_BYTES: begin
                next_prdata = {rx_byte_mem[2], rx_byte_mem[1],
                               rx_byte_mem[0], complete_split_slot_mask};
            end
            `SID_ADDR_BYTES_MID: begin
                next_prdata = {rx_byte_mem[6], rx_byte_mem[5],
                               rx_byte_mem[4], rx_byte_mem[3]};
            end
            `SID_ADDR_BYTES_TOP: begin
                next_prdata = {24'h00_0000, rx_byte_mem[7]};
            end
            `SID_ADDR_CTRL: begin
                next_prdata = ctrl;
            end
            `SID_ADDR_STATE: begin
                next_prdata = {15'h0000, fifo_level, ss_armed,
                               1'b0, last_uframe};
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Zero wait states: the access phase always completes at once
    assign pready = 1'b1;

endmodule // sid_split_desc

`default_nettype wire
